//--- core/fsc_ctrl.v
`timescale 1ns/1ps
`include "fsc_regs.vh"

// Summary of operation
// (RL1) Erase suspend command, then poll status
// (RL2) Erase suspended: ready and suspended bits set
// (RL3) Erase suspended: reads, programs elsewhere allowed
// (RL4) Program in suspend: ready low, suspended kept
// (RL5) Erase suspend accepts reads, status, resume only
// (RL6) Erase resume clears suspend and ready bits
// (RL7) Hold reset high, protect, width during suspend
// (RL8) Erase restarts only after suspend programs
// (RL9) Program suspend command, ready and suspended bits
// (RL10) Program suspend: reads, status, resume only
// (RL11) Program resume clears suspend and ready bits
// (RL12) Program suspend: hold reset, protect, width
// (RL13) Set lock: setup then confirm, poll ready
// (RL14) After set lock check program error, clear
// (RL15) Bad set lock sequence sets both errors
// (RL16) Set lock needs protect high, else errors
// (RL17) Clear lock clears all, protect high only
// (RL18) After clear lock check erase error, clear
// (RL19) Bad clear lock sequence sets both errors
// (RL20) Low supply clear lock sets supply error
// (RL21) Protect low clear lock sets protect error
// (RL22) Aborted clear lock must be repeated
// (RL23) Status pin low busy, floating ready
// (RL24) Command FF returns to read array
// (RL25) Fixed command bytes for every sequence
module fsc_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Flash pins
  output reg [20:0] fl_addr_o,
  input wire [7:0] fl_dq_i,
  output reg [7:0] fl_dq_o,
  output reg fl_dq_oe_o,
  output reg fl_ce_n_o,
  output reg fl_we_n_o,
  output reg fl_oe_n_o,
  output reg fl_wp_n_o,
  output reg fl_rp_n_o,
  output reg fl_byte_n_o,
  input wire status_output_pin_i
);

  // ==========================================================
  // State codes
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_WSET = 6'h02;
  localparam [5:0] ST_WREL = 6'h04;
  localparam [5:0] ST_RSET = 6'h08;
  localparam [5:0] ST_RCAP = 6'h10;
  localparam [5:0] ST_NEXT = 6'h20;
  // Last count of the write and read strobe windows
  localparam [31:0] WE_LAST = `FSC_T_WE_CYC - 1;
  localparam [31:0] RD_LAST = `FSC_T_RD_CYC - 1;

  reg [5:0] state_reg;
  reg [2:0] op_reg;
  reg [1:0] step_reg;
  reg [1:0] cnt_reg;
  reg busy_reg;
  reg poll_reg;
  reg [7:0] sr_reg;
  reg [7:0] rdat_reg;
  reg [7:0] cmd_reg;
  reg sts_meta_reg;
  reg sts_sync_reg;
  reg ers_susp_reg;
  reg prg_susp_reg;
  reg seq_err_reg;

  wire wb_req;
  wire go;
  wire [2:0] go_op;
  wire [1:0] nsteps;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign go = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FSC_ADDR_CTRL)
    & wb_dat_i[`FSC_CTRL_GO] & ~busy_reg;
  assign go_op = wb_dat_i[`FSC_CTRL_OP_MSB:`FSC_CTRL_OP_LSB];
  // Lock operations write two command cycles, the rest one
  assign nsteps = ((op_reg == `FSC_OP_SET_LOCK) || (op_reg == `FSC_OP_CLR_LOCK)) ?
    2'h2 : 2'h1;

  // ==========================================================
  // Command byte for the current step
  always @*
  begin
    cmd_reg = `FSC_CMD_RD_STAT;
    case (op_reg)
      `FSC_OP_ERS_SUSP: cmd_reg = `FSC_CMD_SUSPEND; // RL1
      `FSC_OP_PRG_SUSP: cmd_reg = `FSC_CMD_SUSPEND; // RL9
      `FSC_OP_ERS_RES: cmd_reg = `FSC_CMD_RESUME; // RL6
      `FSC_OP_PRG_RES: cmd_reg = `FSC_CMD_RESUME; // RL11
      `FSC_OP_SET_LOCK: cmd_reg = (step_reg == 2'h0) ? `FSC_CMD_LOCK_SETUP :
        `FSC_CMD_SET_CONFIRM; // RL13
      `FSC_OP_CLR_LOCK: cmd_reg = (step_reg == 2'h0) ? `FSC_CMD_LOCK_SETUP :
        `FSC_CMD_CLR_CONFIRM; // RL17
      `FSC_OP_RD_ARRAY: cmd_reg = `FSC_CMD_RD_ARRAY; // RL24
      default: cmd_reg = `FSC_CMD_RD_STAT; // RL25
    endcase
  end

  // ==========================================================
  // Status pin synchroniser
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sts_meta_reg <= 1'b1;
      sts_sync_reg <= 1'b1;
    end
    else
    begin
      sts_meta_reg <= status_output_pin_i;
      sts_sync_reg <= sts_meta_reg;
    end
  end

  // ==========================================================
  // Wishbone register access
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      fl_wp_n_o <= 1'b1;
      fl_rp_n_o <= 1'b0;
      fl_byte_n_o <= 1'b1;
      fl_addr_o <= 21'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req & wb_we_i & ~busy_reg)
      begin
        // Pin levels are frozen while an operation runs or is suspended
        if (wb_adr_i == `FSC_ADDR_CTRL && wb_sel_i[0] && !ers_susp_reg && !prg_susp_reg)
        begin
          fl_wp_n_o <= wb_dat_i[`FSC_CTRL_WP]; // RL7
          fl_rp_n_o <= wb_dat_i[`FSC_CTRL_RP]; // RL12
          fl_byte_n_o <= wb_dat_i[`FSC_CTRL_BYTE];
        end
        if (wb_adr_i == `FSC_ADDR_ADDR)
          fl_addr_o <= wb_dat_i[20:0];
      end
      if (wb_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          `FSC_ADDR_CTRL: wb_dat_o <= {25'h0, fl_byte_n_o, fl_rp_n_o, fl_wp_n_o,
            1'b0, op_reg};
          `FSC_ADDR_ADDR: wb_dat_o <= {11'h0, fl_addr_o};
          `FSC_ADDR_STAT: wb_dat_o <= {19'h0, seq_err_reg, prg_susp_reg,
            ers_susp_reg, sts_sync_reg, busy_reg, sr_reg};
          `FSC_ADDR_RDAT: wb_dat_o <= {24'h0, rdat_reg};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Flash bus sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      op_reg <= `FSC_OP_RD_STAT;
      step_reg <= 2'h0;
      cnt_reg <= 2'h0;
      busy_reg <= 1'b0;
      poll_reg <= 1'b0;
      sr_reg <= 8'h80;
      rdat_reg <= 8'h0;
      fl_dq_o <= 8'h0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      ers_susp_reg <= 1'b0;
      prg_susp_reg <= 1'b0;
      seq_err_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            op_reg <= go_op;
            step_reg <= 2'h0;
            poll_reg <= 1'b0;
            busy_reg <= 1'b1;
            // Suspend-mode command filter
            if ((ers_susp_reg || prg_susp_reg) && (go_op == `FSC_OP_SET_LOCK ||
              go_op == `FSC_OP_CLR_LOCK || go_op == `FSC_OP_ERS_SUSP ||
              go_op == `FSC_OP_PRG_SUSP || (prg_susp_reg && go_op == `FSC_OP_ERS_RES) ||
              (ers_susp_reg && !prg_susp_reg && go_op == `FSC_OP_PRG_RES))) // RL5 RL10
            begin
              seq_err_reg <= 1'b1;
              busy_reg <= 1'b0;
            end
            // Erase resume is refused with a sequence error while the status pin shows busy
            else if (go_op == `FSC_OP_ERS_RES && !sts_sync_reg) // RL8
            begin
              seq_err_reg <= 1'b1;
              busy_reg <= 1'b0;
            end
            else
            begin
              seq_err_reg <= 1'b0;
              state_reg <= ST_WSET;
            end
          end
        end
        ST_WSET:
        begin
          fl_ce_n_o <= 1'b0;
          fl_we_n_o <= 1'b0;
          fl_dq_o <= cmd_reg;
          fl_dq_oe_o <= 1'b1;
          cnt_reg <= 2'h0;
          state_reg <= ST_WREL;
        end
        ST_WREL:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == WE_LAST[1:0])
          begin
            fl_we_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            fl_dq_oe_o <= 1'b0;
            step_reg <= step_reg + 2'h1;
            if (step_reg + 2'h1 < nsteps)
              state_reg <= ST_WSET;
            else if (op_reg == `FSC_OP_RD_ARRAY)
              state_reg <= ST_RSET;
            else
              state_reg <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          // Device now answers reads with its status register
          poll_reg <= 1'b1;
          state_reg <= ST_RSET;
        end
        ST_RSET:
        begin
          fl_ce_n_o <= 1'b0;
          fl_oe_n_o <= 1'b0;
          cnt_reg <= 2'h0;
          state_reg <= ST_RCAP;
        end
        ST_RCAP:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == RD_LAST[1:0])
          begin
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            if (!poll_reg)
            begin
              rdat_reg <= fl_dq_i;
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else if (!fl_dq_i[`FSC_SR_READY]) // RL23
              state_reg <= ST_RSET;
            else
            begin
              // Keep the error status seen before the automatic clear
              if (op_reg != `FSC_OP_RD_STAT || step_reg != 2'h2)
                sr_reg <= fl_dq_i;
              // Track suspend state from the device's own status bits
              ers_susp_reg <= fl_dq_i[`FSC_SR_ERS_SUSP]; // RL2 RL4 RL6
              prg_susp_reg <= fl_dq_i[`FSC_SR_PRG_SUSP]; // RL9 RL11
              // Lock errors: protect, supply, sequence
              if ((op_reg == `FSC_OP_SET_LOCK && fl_dq_i[`FSC_SR_PRG_ERR]) ||
                (op_reg == `FSC_OP_CLR_LOCK && fl_dq_i[`FSC_SR_ERS_ERR])) // RL14 RL18
              begin
                op_reg <= `FSC_OP_RD_STAT;
                fl_dq_o <= `FSC_CMD_CLR_STAT;
                fl_dq_oe_o <= 1'b1;
                fl_ce_n_o <= 1'b0;
                fl_we_n_o <= 1'b0;
                cnt_reg <= 2'h0;
                step_reg <= 2'h1;
                poll_reg <= 1'b0;
                state_reg <= ST_WREL; // RL15 RL16 RL19 RL20 RL21 RL22
              end
              else
              begin
                busy_reg <= 1'b0;
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Holding the device in reset clears any suspend view
      if (!fl_rp_n_o)
      begin
        ers_susp_reg <= 1'b0;
        prg_susp_reg <= 1'b0;
      end
    end
  end

  // Suspended program and erase may coexist; reads elsewhere allowed
  // RL3

endmodule // fsc_ctrl

//--- core/fsc_regs.vh
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
// Wishbone register offsets (byte addresses)
`define FSC_ADDR_CTRL 4'h0
`define FSC_ADDR_ADDR 4'h4
`define FSC_ADDR_STAT 4'h8
`define FSC_ADDR_RDAT 4'hC
// Control register fields
`define FSC_CTRL_GO 0
`define FSC_CTRL_OP_LSB 1
`define FSC_CTRL_OP_MSB 3
`define FSC_CTRL_WP 4
`define FSC_CTRL_RP 5
`define FSC_CTRL_BYTE 6
// Operation codes written to the control register
`define FSC_OP_ERS_SUSP 3'h0
`define FSC_OP_ERS_RES 3'h1
`define FSC_OP_PRG_SUSP 3'h2
`define FSC_OP_PRG_RES 3'h3
`define FSC_OP_SET_LOCK 3'h4
`define FSC_OP_CLR_LOCK 3'h5
`define FSC_OP_RD_STAT 3'h6
`define FSC_OP_RD_ARRAY 3'h7
// Flash command bytes
`define FSC_CMD_SUSPEND 8'hB0
`define FSC_CMD_RESUME 8'hD0
`define FSC_CMD_LOCK_SETUP 8'h60
`define FSC_CMD_SET_CONFIRM 8'h01
`define FSC_CMD_CLR_CONFIRM 8'hD0
`define FSC_CMD_RD_STAT 8'h70
`define FSC_CMD_RD_ARRAY 8'hFF
`define FSC_CMD_CLR_STAT 8'h50
// Status register bits
`define FSC_SR_READY 7
`define FSC_SR_ERS_SUSP 6
`define FSC_SR_ERS_ERR 5
`define FSC_SR_PRG_ERR 4
`define FSC_SR_SUPPLY_ERR 3
`define FSC_SR_PRG_SUSP 2
`define FSC_SR_PROTECT 1
// Flash bus timing in ns and cycles at 100 ns
`define FSC_CLK_NS 100
`define FSC_T_WE_NS 100
`define FSC_T_WE_CYC ((`FSC_T_WE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_T_RD_NS 200
`define FSC_T_RD_CYC ((`FSC_T_RD_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

//--- tb/fsc_checker.sv
`timescale 1ns/1ps
module fsc_checker (
  // Clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Flash strobes
  input wire fl_ce_n_o,
  input wire fl_we_n_o,
  input wire fl_oe_n_o,
  input wire fl_dq_oe_o
);
  // ==========================================
  // Bus and strobe properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_cmd_drive: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_dq_oe_o && fl_oe_n_o)
    else $error("command write not driven");
  a_cmd_pulse: assert property ($fell(fl_we_n_o) |=> fl_we_n_o)
    else $error("write strobe width");
  a_read_window: assert property ($fell(fl_oe_n_o) |=> !fl_oe_n_o ##1 fl_oe_n_o)
    else $error("read strobe width");
  a_read_free: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o)
    else $error("bus driven during read");
  a_idle_strobes: assert property (fl_ce_n_o |-> fl_we_n_o && fl_oe_n_o)
    else $error("strobe without select");
endmodule // fsc_checker

bind fsc_ctrl fsc_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .fl_ce_n_o, .fl_we_n_o, .fl_oe_n_o, .fl_dq_oe_o);

//--- tb/fsc_flash_model.sv
`timescale 1ns/1ps
module fsc_flash_model (
  // Reference clock and pins
  input wire clk_i,
  input wire [20:0] a_i,
  input wire [7:0] d_i,
  input wire ce_n_i,
  input wire we_n_i,
  input wire oe_n_i,
  input wire wp_n_i,
  input wire rp_n_i,
  // Bench controls: erase start, busy time
  input wire ers_i,
  input wire [7:0] lat_i,
  output reg [7:0] d_o,
  output wire sts_o
);
  reg [7:0] sr;
  reg [7:0] cmd;
  reg [7:0] cnt;
  reg stat_md;
  reg we_q;
  initial d_o = 8'h00;
  assign sts_o = sr[7] ? 1'bz : 1'b0;
  // ==========================================
  // Command decode and busy timer
  always @(posedge clk_i)
  begin
    we_q <= we_n_i;
    if (!rp_n_i)
    begin
      sr <= 8'h80;
      cmd <= 8'h00;
      stat_md <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      if (!sr[7] && cnt == 8'h00)
        sr[7] <= 1'b1;
      else if (!sr[7])
        cnt <= cnt - 8'h01;
      if (ers_i)
      begin
        sr[7] <= 1'b0;
        cnt <= lat_i;
      end
      if (!we_n_i && we_q && !ce_n_i)
      begin
        cmd <= d_i;
        stat_md <= 1'b1;
        if (cmd == 8'h60)
        begin
          if (d_i != 8'h01 && d_i != 8'hD0)
            sr[5:4] <= 2'h3;
          else if (!wp_n_i)
            sr <= sr | (d_i[0] ? 8'h12 : 8'h22);
          else
          begin
            sr[7] <= 1'b0;
            cnt <= lat_i;
          end
        end
        else if (d_i == 8'hD0 && sr[6])
          sr[7:6] <= 2'h0;
        else if (d_i == 8'hB0 && !sr[7])
          sr[7:6] <= 2'h3;
        else if (d_i == 8'h50)
          sr[5:1] <= 5'h00;
        else if (d_i == 8'hFF)
          stat_md <= 1'b0;
      end
    end
  end
  // Released bus toggles so stale data is never seen
  always @(posedge clk_i)
    d_o <= (!oe_n_i && !ce_n_i) ? (stat_md ? sr : a_i[7:0] ^ 8'h5A) : ~d_o;
endmodule // fsc_flash_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "fsc_regs.vh"
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg ers = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h0;
  reg [7:0] lat = 8'h04;
  reg [31:0] v;
  reg [31:0] a;
  wire [31:0] rdat;
  wire [20:0] fa;
  wire [7:0] dq_o;
  wire [7:0] dq_i;
  wire ack, ce_n, we_n, oe_n, dq_oe, wp_n, rp_n, byte_n;
  tri1 sts;
  integer n_errors = 0;
  integer tests_run = 0;
  integer seed = 8;
  integer i;
  always #50 clk_i = ~clk_i;
  fsc_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fl_addr_o(fa), .fl_dq_i(dq_i), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe), .fl_ce_n_o(ce_n),
    .fl_we_n_o(we_n), .fl_oe_n_o(oe_n), .fl_wp_n_o(wp_n), .fl_rp_n_o(rp_n),
    .fl_byte_n_o(byte_n), .status_output_pin_i(sts));
  fsc_flash_model u_flash (.clk_i, .a_i(fa), .d_i(dq_o), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .wp_n_i(wp_n), .rp_n_i(rp_n), .ers_i(ers), .lat_i(lat), .d_o(dq_i),
    .sts_o(sts));
  // ==========================================
  // Tasks
  task final_report;
    begin
      if (n_errors == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [3:0] ad, input [31:0] d);
    integer k;
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= ad;
      wdat <= d;
      k = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && k < 50)
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      v = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      if (k == 50)
      begin
        n_errors = n_errors + 1;
        final_report;
      end
      @(posedge clk_i);
    end
  endtask
  // Start an operation and poll until busy clears
  task op(input [2:0] o, input w);
    integer k;
    begin
      wb(1'b1, `FSC_ADDR_CTRL, {25'h0, 1'b1, 1'b1, w, o, 1'b1});
      k = 0;
      v = 32'h100;
      while (v[8] && k < 900)
      begin
        wb(1'b0, `FSC_ADDR_STAT, 32'h0);
        k = k + 1;
      end
      if (k == 900)
      begin
        n_errors = n_errors + 1;
        final_report;
      end
    end
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `FSC_ADDR_CTRL, 32'h60);
    wb(1'b0, `FSC_ADDR_CTRL, 32'h0);
    chk(v, {25'h0, 3'b110, 1'b0, `FSC_OP_RD_STAT});
    chk({29'h0, byte_n, rp_n, wp_n}, 32'h6);
    for (i = 0; i < 2; i = i + 1)
    begin
      lat <= 8'($random(seed)) | 8'h01;
      op(`FSC_OP_SET_LOCK, i[0]);
      chk(v[7:0], i ? 8'h80 : 8'h92);
      op(`FSC_OP_CLR_LOCK, i[0]);
      chk(v[7:0], i ? 8'h80 : 8'hA2);
    end
    lat <= 8'hC8;
    ers <= 1'b1;
    @(posedge clk_i);
    ers <= 1'b0;
    op(`FSC_OP_ERS_SUSP, 1'b1);
    chk(v[12:0], 13'h06C0);
    op(`FSC_OP_SET_LOCK, 1'b1);
    chk(v[12], 1'b1);
    op(`FSC_OP_ERS_RES, 1'b1);
    chk(v[12:0], 13'h0280);
    op(`FSC_OP_RD_STAT, 1'b1);
    chk(v[7:0], 8'h80);
    a = 32'($random(seed)) & 32'h1FFFFF;
    wb(1'b1, `FSC_ADDR_ADDR, a);
    op(`FSC_OP_RD_ARRAY, 1'b1);
    wb(1'b0, `FSC_ADDR_RDAT, 32'h0);
    chk(v, {24'h0, a[7:0] ^ 8'h5A});
    wb(1'b0, 4'h2, 32'h0);
    chk(v, 32'h0);
    final_report;
  end
endmodule // tb_top
